//--- rtl/pin_mux_pkg.sv
// Shared constants and types for the test and port pin multiplexer.
// Assumes one system clock domain; all pins arrive asynchronously.
package pin_mux_pkg;

    // ------------------------------------------------------------------
    // Pin indices into the pad vectors
    // ------------------------------------------------------------------
    localparam int NUM_PINS = 7;
    localparam int PIN_B5   = 0;
    localparam int PIN_D2   = 1;
    localparam int PIN_D3   = 2;
    localparam int PIN_D0   = 3;
    localparam int PIN_D1   = 4;
    localparam int PIN_B0   = 5;
    localparam int PIN_B1   = 6;

    // ------------------------------------------------------------------
    // Function select codes held by the integration settings
    // ------------------------------------------------------------------
    localparam logic [1:0] FUNC_PORT = 2'h0;
    localparam logic [1:0] FUNC_ALT1 = 2'h1;
    localparam logic [1:0] FUNC_ALT2 = 2'h2;

    // Test port bits: one per port D line, set means test function
    localparam int JTAG_D0 = 0;
    localparam int JTAG_D1 = 1;
    localparam int JTAG_D2 = 2;
    localparam int JTAG_D3 = 3;

    // ------------------------------------------------------------------
    // Reset values of the selections
    // ------------------------------------------------------------------
    localparam logic [1:0] B5_SEL_RESET   = FUNC_PORT;
    localparam logic [1:0] B0_SEL_RESET   = FUNC_PORT;
    localparam logic [1:0] B1_SEL_RESET   = FUNC_PORT;
    localparam logic [3:0] JTAG_SEL_RESET = 4'hf;

    // ------------------------------------------------------------------
    // Test access port controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAP_DR     = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAP_IR     = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } tap_state_type;

endpackage

//--- rtl/tap_state_tracker.sv
// Test access port controller state machine.
// Assumes test clock edges arrive as one-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none

module tap_state_tracker
    import pin_mux_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    input  wire logic    tck_rise_i,
    input  wire logic    tms_i,
    output tap_state_type state_o
);

    tap_state_type state_d;

    // ------------------------------------------------------------------
    // Next state, taken only on a rising test clock edge
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_o;
        if (tck_rise_i) begin
            case (state_o)
                TAP_RESET:     state_d = tms_i ? TAP_RESET : TAP_IDLE;
                TAP_IDLE:      state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR:    state_d = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR:    state_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR:  state_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR:  state_d = tms_i ? TAP_UPDATE_DR : TAP_PAUSE_DR;
                TAP_PAUSE_DR:  state_d = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR:  state_d = tms_i ? TAP_UPDATE_DR : TAP_SHIFT_DR;
                TAP_UPDATE_DR: state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR:    state_d = tms_i ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR:    state_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR:  state_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR:  state_d = tms_i ? TAP_UPDATE_IR : TAP_PAUSE_IR;
                TAP_PAUSE_IR:  state_d = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR:  state_d = tms_i ? TAP_UPDATE_IR : TAP_SHIFT_IR;
                TAP_UPDATE_IR: state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
                default:       state_d = TAP_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_o <= TAP_RESET;
        end else begin
            state_o <= state_d;
        end
    end

endmodule

`default_nettype wire

//--- rtl/test_and_port_pin_mux.sv
// Pin function multiplexer for one port B line, four port D / test lines
// and the two port B lines shared with SPI and I2C.
// Assumes pads resolve pin levels from out/oe_n; all pad inputs are async.
//
// Summary of operation
// - Integration settings choose port or peripheral function per pin.
// - Port B line five resets to port; alternates timer one, fault three.
// - Port D line two resets to test clock function.
// - Port D line three resets to test mode select function.
// - Port D line zero resets to test data input function.
// - Port D line one resets to test data output function.
// - Port B line zero resets to port; alternates SPI clock, I2C clock.
// - In port mode each pin has its own software direction.
// - Test clock paces test logic and serial shifting.
// - Mode select sampled on rising test clock advances TAP controller.
// - Test data input sampled on rising test clock edge.
// - Test data output driven only in Shift-IR and Shift-DR.
// - Test data output changes on falling test clock edge.
// - Asserted fault input disables the selected PWM outputs.
// - SPI master drives the serial clock pin as an output.
// - SPI slave takes the serial clock pin as data clock input.
// - SPI slave receives only while slave select is asserted.
`timescale 1ns/1ps
`default_nettype none

module test_and_port_pin_mux
    import pin_mux_pkg::*;
#(
    parameter int PWM_CHANNELS = 6
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Integration settings
    input  wire logic                    sim_load_i,
    input  wire logic [1:0]              b5_sel_i,
    input  wire logic [1:0]              b0_sel_i,
    input  wire logic [1:0]              b1_sel_i,
    input  wire logic [3:0]              jtag_sel_i,
    // Pads
    input  wire logic [NUM_PINS-1:0]     pad_in_i,
    output logic      [NUM_PINS-1:0]     pad_out_o,
    output logic      [NUM_PINS-1:0]     pad_oe_n_o,
    // Port logic
    input  wire logic [NUM_PINS-1:0]     port_dir_i,
    input  wire logic [NUM_PINS-1:0]     port_out_i,
    output logic      [NUM_PINS-1:0]     port_in_o,
    // Timer channel one
    input  wire logic                    timer_out_i,
    input  wire logic                    timer_oe_i,
    output logic                         timer_in_o,
    // PWM fault gating
    input  wire logic [PWM_CHANNELS-1:0] pwm_i,
    input  wire logic [PWM_CHANNELS-1:0] pwm_fault_mask_i,
    output logic      [PWM_CHANNELS-1:0] pwm_o,
    output logic                         fault_three_o,
    // SPI
    input  wire logic                    spi_master_i,
    input  wire logic                    spi_sclk_out_i,
    output logic                         spi_sclk_in_o,
    output logic                         spi_ss_n_o,
    output logic                         spi_rx_enable_o,
    // I2C, open drain: a drive request pulls the line low
    input  wire logic                    i2c_scl_low_i,
    input  wire logic                    i2c_sda_low_i,
    output logic                         i2c_scl_in_o,
    output logic                         i2c_sda_in_o,
    // Test port
    input  wire logic                    tdo_data_i,
    output logic                         tck_rise_o,
    output logic                         tck_fall_o,
    output logic                         tms_o,
    output logic                         tdi_o,
    output tap_state_type                tap_state_o
);

    // ------------------------------------------------------------------
    // Pad input synchronisers
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] pin_q;

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync1_q[i] <= 1'b1;
                pin_q[i]   <= 1'b1;
            end else begin
                sync1_q[i] <= pad_in_i[i];
                pin_q[i]   <= sync1_q[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Function selection
    // ------------------------------------------------------------------
    logic [1:0] b5_sel_q;
    logic [1:0] b0_sel_q;
    logic [1:0] b1_sel_q;
    logic [3:0] jtag_sel_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b5_sel_q   <= B5_SEL_RESET;
            b0_sel_q   <= B0_SEL_RESET;
            b1_sel_q   <= B1_SEL_RESET;
            jtag_sel_q <= JTAG_SEL_RESET;
        end else if (sim_load_i) begin
            b5_sel_q   <= b5_sel_i;
            b0_sel_q   <= b0_sel_i;
            b1_sel_q   <= b1_sel_i;
            jtag_sel_q <= jtag_sel_i;
        end
    end

    logic b5_timer;
    logic b5_fault;
    logic b0_spi;
    logic b0_i2c;
    logic b1_spi;
    logic b1_i2c;

    // Reserved code 3 falls back to port mode
    assign b5_timer = (b5_sel_q == FUNC_ALT1);
    assign b5_fault = (b5_sel_q == FUNC_ALT2);
    assign b0_spi   = (b0_sel_q == FUNC_ALT1);
    assign b0_i2c   = (b0_sel_q == FUNC_ALT2);
    assign b1_spi   = (b1_sel_q == FUNC_ALT1);
    assign b1_i2c   = (b1_sel_q == FUNC_ALT2);

    // ------------------------------------------------------------------
    // Test clock edge detection and test inputs
    // ------------------------------------------------------------------
    logic tck_lvl;
    logic tms_lvl;
    logic tdi_lvl;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;

    // Unselected test inputs sit high, so the controller sees at most one last rising edge
    assign tck_lvl = jtag_sel_q[JTAG_D2] ? pin_q[PIN_D2] : 1'b1;
    assign tms_lvl = jtag_sel_q[JTAG_D3] ? pin_q[PIN_D3] : 1'b1;
    assign tdi_lvl = jtag_sel_q[JTAG_D0] ? pin_q[PIN_D0] : 1'b1;

    assign tck_rise = tck_lvl & ~tck_prev_q;
    assign tck_fall = ~tck_lvl & tck_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_prev_q <= 1'b1;
            tck_rise_o <= 1'b0;
            tck_fall_o <= 1'b0;
        end else begin
            tck_prev_q <= tck_lvl;
            tck_rise_o <= tck_rise;
            tck_fall_o <= tck_fall;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tms_o <= 1'b1;
            tdi_o <= 1'b1;
        end else if (tck_rise) begin
            tms_o <= tms_lvl;
            tdi_o <= tdi_lvl;
        end
    end

    tap_state_tracker u_tap (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tck_rise_i (tck_rise),
        .tms_i      (tms_lvl),
        .state_o    (tap_state_o)
    );

    // ------------------------------------------------------------------
    // Test data output, retimed to the falling test clock edge
    // ------------------------------------------------------------------
    logic tdo_val_q;
    logic tdo_en_q;
    logic in_shift;

    assign in_shift = (tap_state_o == TAP_SHIFT_DR) ||
                      (tap_state_o == TAP_SHIFT_IR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_val_q <= 1'b0;
            tdo_en_q  <= 1'b0;
        end else if (tck_fall) begin
            tdo_val_q <= tdo_data_i;
            tdo_en_q  <= in_shift;
        end
    end

    // ------------------------------------------------------------------
    // Pad output and enable selection
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] out_d;
    logic [NUM_PINS-1:0] oe_d;

    always_comb begin
        out_d = port_out_i;
        oe_d  = port_dir_i;
        // Port B line five
        if (b5_timer) begin
            out_d[PIN_B5] = timer_out_i;
            oe_d[PIN_B5]  = timer_oe_i;
        end else if (b5_fault) begin
            out_d[PIN_B5] = 1'b0;
            oe_d[PIN_B5]  = 1'b0;
        end
        // Test input pins never drive
        if (jtag_sel_q[JTAG_D2]) begin
            out_d[PIN_D2] = 1'b0;
            oe_d[PIN_D2]  = 1'b0;
        end
        if (jtag_sel_q[JTAG_D3]) begin
            out_d[PIN_D3] = 1'b0;
            oe_d[PIN_D3]  = 1'b0;
        end
        if (jtag_sel_q[JTAG_D0]) begin
            out_d[PIN_D0] = 1'b0;
            oe_d[PIN_D0]  = 1'b0;
        end
        if (jtag_sel_q[JTAG_D1]) begin
            out_d[PIN_D1] = tdo_val_q;
            oe_d[PIN_D1]  = tdo_en_q;
        end
        // Port B line zero
        if (b0_spi) begin
            out_d[PIN_B0] = spi_sclk_out_i;
            oe_d[PIN_B0]  = spi_master_i;
        end else if (b0_i2c) begin
            out_d[PIN_B0] = 1'b0;
            oe_d[PIN_B0]  = i2c_scl_low_i;
        end
        // Port B line one
        if (b1_spi) begin
            out_d[PIN_B1] = 1'b0;
            oe_d[PIN_B1]  = 1'b0;
        end else if (b1_i2c) begin
            out_d[PIN_B1] = 1'b0;
            oe_d[PIN_B1]  = i2c_sda_low_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o  <= '0;
            pad_oe_n_o <= '1;
        end else begin
            pad_out_o  <= out_d;
            pad_oe_n_o <= ~oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Peripheral inputs
    // ------------------------------------------------------------------
    logic spi_slave;
    logic fault_now;

    assign spi_slave = b0_spi & ~spi_master_i;
    assign fault_now = b5_fault & pin_q[PIN_B5];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_in_o     <= '1;
            timer_in_o    <= 1'b0;
            fault_three_o <= 1'b0;
            pwm_o         <= '0;
        end else begin
            port_in_o     <= pin_q;
            timer_in_o    <= b5_timer & pin_q[PIN_B5];
            fault_three_o <= fault_now;
            pwm_o         <= pwm_i & ~(pwm_fault_mask_i & {PWM_CHANNELS{fault_now}});
        end
    end

    // Slave select gates reception only in slave mode; spi_ss_n_o follows it in master mode too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_sclk_in_o   <= 1'b0;
            spi_ss_n_o      <= 1'b1;
            spi_rx_enable_o <= 1'b0;
        end else begin
            spi_sclk_in_o   <= spi_slave & pin_q[PIN_B0];
            spi_ss_n_o      <= ~(b1_spi & ~pin_q[PIN_B1]);
            spi_rx_enable_o <= spi_slave & b1_spi & ~pin_q[PIN_B1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            i2c_scl_in_o <= 1'b1;
            i2c_sda_in_o <= 1'b1;
        end else begin
            i2c_scl_in_o <= b0_i2c ? pin_q[PIN_B0] : 1'b1;
            i2c_sda_in_o <= b1_i2c ? pin_q[PIN_B1] : 1'b1;
        end
    end

endmodule

`default_nettype wire

//--- verification/pin_mux_assertions.sv
// Checker for the pin multiplexer, bound to its top ports.
// Assumes selects act one edge after a load and reach the pads one later.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_assertions
    import pin_mux_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                sim_load_i,
    input wire logic [1:0]          b0_sel_i,
    input wire logic [1:0]          b1_sel_i,
    input wire logic [3:0]          jtag_sel_i,
    input wire logic [NUM_PINS-1:0] pad_out_o,
    input wire logic [NUM_PINS-1:0] pad_oe_n_o,
    input wire logic [NUM_PINS-1:0] port_dir_i,
    input wire logic                spi_master_i,
    input wire logic                spi_sclk_out_i,
    input wire logic                tck_rise_o,
    input wire logic                tck_fall_o,
    input wire logic                tms_o,
    input wire tap_state_type       tap_state_o
);
    logic       spi_q, port_q, d1_q, d2_q;
    logic [2:0] age_q;
    logic [3:0] idle_q;

    // ------------------------------------------------------------------
    // Select mirror
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {spi_q, port_q, d1_q, d2_q} <= 4'h7;
        end else if (sim_load_i) begin
            spi_q  <= b0_sel_i == FUNC_ALT1;
            port_q <= b1_sel_i == FUNC_PORT;
            d1_q   <= jtag_sel_i[JTAG_D1];
            d2_q   <= jtag_sel_i[JTAG_D2];
        end
    end
    // Pads are trusted only once a load has settled
    always_ff @(posedge clk_i) begin
        if (rst_i || sim_load_i) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    // Margin for the last edge left over when the test clock is taken away
    always_ff @(posedge clk_i) begin
        if (rst_i || d2_q) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hf) begin
            idle_q <= idle_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rst_off; disable iff (1'b0) $past(rst_i) |-> &pad_oe_n_o;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("drive in reset");
    property p_b1_dir;
        age_q > 3'h2 && port_q |-> pad_oe_n_o[PIN_B1] == !$past(port_dir_i[PIN_B1]);
    endproperty
    a_b1_dir: assert property (p_b1_dir) else $error("b1 direction");
    property p_sclk_out;
        age_q > 3'h2 && spi_q && $past(spi_master_i) |-> !pad_oe_n_o[PIN_B0]
            && pad_out_o[PIN_B0] == $past(spi_sclk_out_i);
    endproperty
    a_sclk_out: assert property (p_sclk_out) else $error("sclk drive");
    property p_tdo_en;
        age_q > 3'h2 && d1_q && $fell(pad_oe_n_o[PIN_D1])
            |-> tap_state_o inside {TAP_SHIFT_DR, TAP_SHIFT_IR};
    endproperty
    a_tdo_en: assert property (p_tdo_en) else $error("tdo enable");
    property p_tdo_fall;
        age_q > 3'h3 && d1_q && !pad_oe_n_o[PIN_D1] && $changed(pad_out_o[PIN_D1])
            |-> $past(tck_fall_o) || $past(tck_fall_o, 2);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo edge");
    property p_idle_step; tck_rise_o && $past(tap_state_o) == TAP_IDLE
        |-> tap_state_o == (tms_o ? TAP_SEL_DR : TAP_IDLE); endproperty
    a_idle_step: assert property (p_idle_step) else $error("tap step");
    property p_tap_hold; !tck_rise_o |-> $stable(tap_state_o); endproperty
    a_tap_hold: assert property (p_tap_hold) else $error("tap moved");
    property p_tck_gone; idle_q == 4'hf |-> !tck_rise_o && !tck_fall_o;
    endproperty
    a_tck_gone: assert property (p_tck_gone) else $error("tck edge");

    c_shift_dr: cover property (tap_state_o == TAP_SHIFT_DR);
    c_tdo_drive: cover property (d1_q && !pad_oe_n_o[PIN_D1]);
    c_spi_drive: cover property (spi_q && !pad_oe_n_o[PIN_B0]);
endmodule

bind test_and_port_pin_mux pin_mux_assertions i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .sim_load_i(sim_load_i),
    .b0_sel_i(b0_sel_i), .b1_sel_i(b1_sel_i), .jtag_sel_i(jtag_sel_i),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
    .port_dir_i(port_dir_i), .spi_master_i(spi_master_i),
    .spi_sclk_out_i(spi_sclk_out_i), .tck_rise_o(tck_rise_o),
    .tck_fall_o(tck_fall_o), .tms_o(tms_o), .tap_state_o(tap_state_o)
);
`default_nettype wire

//--- verification/board_probe.sv
// Board model: test probe and the devices on the port B pins.
// Assumes a pull-up on every pin, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module board_probe
    import pin_mux_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pad_out_i,
    input  wire logic [NUM_PINS-1:0] pad_oe_n_i,
    output logic      [NUM_PINS-1:0] pad_level_o
);
    logic [NUM_PINS-1:0] drv_en  = '0;
    logic [NUM_PINS-1:0] drv_val = '0;

    // Our drive wins over the device's; a clash is not modelled
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pad_level_o[i] = !pad_oe_n_i[i] ? pad_out_i[i]
                           : (drv_en[i] ? drv_val[i] : 1'b1);
        end
    end

    task automatic drive(input int pin, input logic val);
        drv_en[pin]  = 1'b1;
        drv_val[pin] = val;
    endtask

    task automatic release_pin(input int pin);
        drv_en[pin] = 1'b0;
    endtask

    // One 125 ns test clock period; the clock then stands still high
    task automatic tap_step(input logic tms, input logic tdi);
        drv_en[PIN_D2]  = 1'b1;
        drv_en[PIN_D3]  = 1'b1;
        drv_en[PIN_D0]  = 1'b1;
        drv_val[PIN_D3] = tms;
        drv_val[PIN_D0] = tdi;
        drv_val[PIN_D2] = 1'b0;
        #62.5;
        drv_val[PIN_D2] = 1'b1;
        #62.5;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the test and port pin multiplexer.
// Assumes the board model resolves every pad level.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pin_mux_pkg::*;
;
    logic                clk_i = 1'b0, rst_i = 1'b1, sim_load_i = 1'b0;
    logic [1:0]          b5_sel_i = 2'h0, b0_sel_i = 2'h0, b1_sel_i = 2'h0;
    logic [3:0]          jtag_sel_i = 4'hf;
    logic [NUM_PINS-1:0] port_dir_i = 7'h7f, port_out_i = 7'h57;
    logic [5:0]          pwm_i = 6'h00, pwm_fault_mask_i = 6'h00, pwm_o;
    logic                timer_out_i = 1'b0, timer_oe_i = 1'b0;
    logic                spi_master_i = 1'b0, spi_sclk_out_i = 1'b0;
    logic                i2c_scl_low_i = 1'b0, i2c_sda_low_i = 1'b0;
    logic                tdo_data_i = 1'b0, timer_in_o, fault_three_o;
    logic [NUM_PINS-1:0] pad_level, pad_out_o, pad_oe_n_o, port_in_o;
    logic                spi_sclk_in_o, spi_ss_n_o, spi_rx_enable_o;
    logic                i2c_scl_in_o, i2c_sda_in_o;
    logic                tck_rise_o, tck_fall_o, tms_o, tdi_o;
    tap_state_type       tap_state_o;
    int                  fail_count = 0, n_compared = 0;
    test_and_port_pin_mux #(.PWM_CHANNELS(6)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sim_load_i(sim_load_i),
        .b5_sel_i(b5_sel_i), .b0_sel_i(b0_sel_i), .b1_sel_i(b1_sel_i),
        .jtag_sel_i(jtag_sel_i), .pad_in_i(pad_level),
        .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .port_dir_i(port_dir_i), .port_out_i(port_out_i),
        .port_in_o(port_in_o), .timer_out_i(timer_out_i),
        .timer_oe_i(timer_oe_i), .timer_in_o(timer_in_o), .pwm_i(pwm_i),
        .pwm_fault_mask_i(pwm_fault_mask_i), .pwm_o(pwm_o),
        .fault_three_o(fault_three_o), .spi_master_i(spi_master_i),
        .spi_sclk_out_i(spi_sclk_out_i), .spi_sclk_in_o(spi_sclk_in_o),
        .spi_ss_n_o(spi_ss_n_o), .spi_rx_enable_o(spi_rx_enable_o),
        .i2c_scl_low_i(i2c_scl_low_i), .i2c_sda_low_i(i2c_sda_low_i),
        .i2c_scl_in_o(i2c_scl_in_o), .i2c_sda_in_o(i2c_sda_in_o),
        .tdo_data_i(tdo_data_i), .tck_rise_o(tck_rise_o),
        .tck_fall_o(tck_fall_o), .tms_o(tms_o), .tdi_o(tdi_o),
        .tap_state_o(tap_state_o));

    board_probe i_board (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pad_level_o(pad_level));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic load(input logic [1:0] b5, b0, b1, input logic [3:0] j);
        {b5_sel_i, b0_sel_i, b1_sel_i, jtag_sel_i} = {b5, b0, b1, j};
        sim_load_i = 1'b1;
        tick(1);
        sim_load_i = 1'b0;
        tick(4);
    endtask

    // Resynchronise to the clock so checks never land on an edge
    task automatic step(input logic tms, input logic tdi);
        i_board.tap_step(tms, tdi);
        tick(1);
    endtask

    task automatic steps(input logic [15:0] tms, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            step(tms[i], 1'b1);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("oe_n in reset", 16'h7f, pad_oe_n_o);
        rst_i = 1'b0;
        tick(3);
        chk("oe_n default", 16'h1e, pad_oe_n_o);
        chk("out default", 16'h41, pad_out_o & 7'h61);
        port_dir_i = 7'h21;
        tick(2);
        chk("oe_n per pin", 16'h5e, pad_oe_n_o);
        chk("port in", 16'h5f, port_in_o);
    endtask

    task automatic t_port();
        port_dir_i = 7'h7f;
        load(FUNC_PORT, FUNC_PORT, FUNC_PORT, 4'h0);
        chk("oe_n all port", 16'h00, pad_oe_n_o);
        chk("out all port", 16'h57, pad_out_o);
        steps(16'h0, 3);
        chk("tap undisturbed", TAP_RESET, tap_state_o);
        port_dir_i = 7'h21;
        load(FUNC_PORT, FUNC_PORT, FUNC_PORT, 4'h7);
        step(1'b0, 1'b0);
        chk("tms inactive", 16'h1, tms_o);
        chk("tap still", TAP_RESET, tap_state_o);
        load(FUNC_PORT, FUNC_PORT, FUNC_PORT, 4'hf);
    endtask

    task automatic t_jtag();
        tdo_data_i = 1'b1;
        steps(16'h1f4, 9);
        chk("shift dr", TAP_SHIFT_DR, tap_state_o);
        chk("tdo off", 16'h1, pad_oe_n_o[PIN_D1]);
        step(1'b0, 1'b0);
        chk("tdi", 16'h0, tdi_o);
        chk("tdo on", 16'h0, pad_oe_n_o[PIN_D1]);
        chk("tdo bit", 16'h1, pad_out_o[PIN_D1]);
        tdo_data_i = 1'b0;
        tick(8);
        chk("tdo before fall", 16'h1, pad_out_o[PIN_D1]);
        step(1'b0, 1'b1);
        chk("tdo after fall", 16'h0, pad_out_o[PIN_D1]);
        steps(16'h3, 2);
        chk("tdo released", 16'h1, pad_oe_n_o[PIN_D1]);
        steps(16'hc, 4);
        chk("shift ir", TAP_SHIFT_IR, tap_state_o);
        step(1'b0, 1'b1);
        chk("tdo on ir", 16'h0, pad_oe_n_o[PIN_D1]);
    endtask

    task automatic t_b5();
        {timer_oe_i, pwm_i, pwm_fault_mask_i} = {1'b1, 6'h3f, 6'h0f};
        load(FUNC_ALT1, FUNC_PORT, FUNC_PORT, 4'hf);
        tick(4);
        chk("timer drive", 16'h0, {pad_oe_n_o[PIN_B5], pad_out_o[PIN_B5]});
        chk("timer in", 16'h0, timer_in_o);
        i_board.drive(PIN_B5, 1'b1);
        load(FUNC_ALT2, FUNC_PORT, FUNC_PORT, 4'hf);
        tick(4);
        chk("fault pin off", 16'h1, pad_oe_n_o[PIN_B5]);
        chk("fault", 16'h1, fault_three_o);
        chk("pwm gated", 16'h30, pwm_o);
        i_board.drive(PIN_B5, 1'b0);
        tick(6);
        chk("pwm free", 16'h3f, pwm_o);
    endtask

    task automatic t_spi_i2c();
        {spi_master_i, spi_sclk_out_i} = 2'h3;
        load(FUNC_PORT, FUNC_ALT1, FUNC_ALT1, 4'hf);
        chk("sclk out", 16'h1, {pad_oe_n_o[PIN_B0], pad_out_o[PIN_B0]});
        chk("ss input", 16'h1, pad_oe_n_o[PIN_B1]);
        spi_master_i = 1'b0;
        i_board.drive(PIN_B0, 1'b1);
        i_board.drive(PIN_B1, 1'b0);
        tick(6);
        chk("sclk in", 16'h3, {pad_oe_n_o[PIN_B0], spi_sclk_in_o});
        chk("rx on", 16'h1, {spi_ss_n_o, spi_rx_enable_o});
        i_board.drive(PIN_B1, 1'b1);
        tick(6);
        chk("rx off", 16'h2, {spi_ss_n_o, spi_rx_enable_o});
        i_board.release_pin(PIN_B0);
        i2c_scl_low_i = 1'b1;
        i_board.drive(PIN_B1, 1'b0);
        load(FUNC_PORT, FUNC_ALT2, FUNC_ALT2, 4'hf);
        chk("scl low", 16'h0, {pad_oe_n_o[PIN_B0], pad_out_o[PIN_B0]});
        i2c_scl_low_i = 1'b0;
        tick(6);
        chk("i2c in", 16'h2, {i2c_scl_in_o, i2c_sda_in_o});
    endtask

    initial begin
        #100000;
        fail_count++;
        conclude();
    end

    initial begin
        tick(6);
        t_reset();
        t_port();
        t_jtag();
        t_b5();
        t_spi_i2c();
        conclude();
    end
endmodule
`default_nettype wire
